// [uafc_path.sv]
// Purpose: Transmit/receive queues, shifters and auto RTS/CTS flow control
// Assumes: os_tick_i is a one-cycle pulse at the oversample rate
// Notes: Baud generator, software flow control and sleep are outside
`timescale 1ns/10ps
`include "uafc_defs.svh"

module uafc_path #(
    parameter int DEPTH = `UAFC_DEPTH
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic os_tick_i,
    input wire logic tx_write_i,
    input wire logic [7:0] tx_data_i,
    input wire logic rx_read_i,
    output logic [7:0] rx_data_o,
    input wire logic isr_read_i,
    input wire logic [7:0] interrupt_enable_i,
    input wire logic [7:0] enhanced_feature_i,
    input wire logic [7:0] modem_control_i,
    input wire logic [7:0] queue_control_i,
    input wire logic [7:0] fractional_divisor_i,
    input wire logic [7:0] line_control_i,
    input wire logic rx_i,
    input wire logic cts_n_i,
    output logic tx_o,
    output logic rts_n_o,
    output logic [7:0] line_status_o,
    output logic [7:0] interrupt_source_o,
    output logic irq_o
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] FULL = AW'(DEPTH) == '0 ? (AW+1)'(DEPTH)
                                                   : (AW+1)'(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][7:0] txq;
        logic [AW-1:0] tx_wp;
        logic [AW-1:0] tx_rp;
        logic [AW:0] tx_cnt;
        logic [DEPTH-1:0][10:0] rxq;
        logic [AW-1:0] rx_wp;
        logic [AW-1:0] rx_rp;
        logic [AW:0] rx_cnt;
        logic [1:0] rx_sync;
        logic rx_prev;
        logic [1:0] cts_sync;
        logic cts_prev;
        uafc_pkg::uafc_rx_st_t rx_st;
        logic [4:0] rx_tick;
        logic [2:0] rx_bit;
        uafc_pkg::uafc_rx_entry_t rx_ent;
        logic rx_push;
        uafc_pkg::uafc_tx_st_t tx_st;
        logic [4:0] tx_tick;
        logic [2:0] tx_bit;
        logic [7:0] tx_sh;
        logic tx_par;
        logic tx_stop2;
        logic tx_line;
        logic ovr;
        logic thr_prev;
        logic tx_pend;
        logic flow_pend;
        logic rts_off;
        logic rts_n;
        logic [11:0] to_cnt;
        logic to_pend;
    } uafc_st_t;

    function automatic uafc_st_t init_st();
        init_st = '0;
        init_st.rx_sync = 2'h3;
        init_st.rx_prev = 1'b1;
        init_st.rx_st = uafc_pkg::UAFC_RX_IDLE;
        init_st.tx_st = uafc_pkg::UAFC_TX_IDLE;
        init_st.tx_line = 1'b1;
        // Queue starts empty; no false tx-empty edge after reset
        init_st.thr_prev = 1'b1;
        init_st.rts_n = 1'b1;
    endfunction

    // Ticks per bit for the selected oversampling rate
    function automatic logic [4:0] bit_ticks(input logic [7:0] fd);
        case (fd[`UAFC_DLD_OS_HI:`UAFC_DLD_OS_LO])
            `UAFC_OS_16X: bit_ticks = `UAFC_OS16;
            `UAFC_OS_8X: bit_ticks = `UAFC_OS8;
            default: bit_ticks = `UAFC_OS4;
        endcase
    endfunction

    function automatic logic [3:0] char_bits(input logic [7:0] lc);
        char_bits = `UAFC_WL_MIN + {2'h0, lc[`UAFC_LCR_WL_HI:`UAFC_LCR_WL_LO]};
    endfunction

    function automatic logic [7:0] wl_mask(input logic [7:0] lc);
        wl_mask = 8'hff >> (2'h3 - lc[`UAFC_LCR_WL_HI:`UAFC_LCR_WL_LO]);
    endfunction

    // Parity bit: odd unless even parity selected
    function automatic logic par_bit(input logic [7:0] d,
                                     input logic [7:0] lc);
        par_bit = (^d) ^ ~lc[`UAFC_LCR_EPS];
    endfunction

    // Trigger level, RTS-off level and RTS-on level per selection
    function automatic logic [6:0] trig_lvl(input logic [1:0] sel,
                                            input logic [1:0] which);
        logic [6:0] t [4];
        t[0] = `UAFC_TRIG_8;
        t[1] = `UAFC_TRIG_16;
        t[2] = `UAFC_TRIG_56;
        t[3] = `UAFC_TRIG_60;
        case (which)
            2'h1: trig_lvl = (sel == 2'h3) ? t[3] : t[sel + 2'h1];
            2'h2: trig_lvl = (sel == 2'h0) ? `UAFC_CNT_ZERO
                                           : t[sel - 2'h1];
            default: trig_lvl = t[sel];
        endcase
    endfunction

    uafc_st_t st;
    uafc_st_t next_st;
    logic qen;
    logic [AW:0] limit;
    logic [4:0] div;
    logic [1:0] tsel;
    logic rx_s;
    logic cts_s;
    logic buf_in_ready;
    logic buf_valid;
    logic [10:0] buf_data;
    logic rxq_push;
    logic rxq_pop;
    logic txq_push;
    logic txq_pop;
    logic thr_empty;
    logic tx_halt;
    logic auto_rts;
    logic rx_int;
    logic [11:0] to_limit;
    logic [7:0] interrupt_enable;
    uafc_pkg::uafc_rx_entry_t head;

    assign qen = queue_control_i[`UAFC_FCR_EN];
    assign limit = qen ? FULL : (AW+1)'(1);
    assign div = bit_ticks(fractional_divisor_i);
    assign tsel = queue_control_i[`UAFC_FCR_TRIG_HI:`UAFC_FCR_TRIG_LO];
    assign rx_s = st.rx_sync[1];
    assign cts_s = st.cts_sync[1];
    // Upper enables only take effect with enhanced features on
    assign interrupt_enable = {interrupt_enable_i[7:6] & {2{enhanced_feature_i[
                  `UAFC_EFR_ENH]}}, interrupt_enable_i[5:0]};
    assign head = st.rxq[st.rx_rp];
    assign rxq_push = buf_valid && (st.rx_cnt < limit);
    assign rxq_pop = rx_read_i && (st.rx_cnt != '0);
    assign txq_push = tx_write_i && (st.tx_cnt < limit);
    assign thr_empty = (st.tx_cnt == '0);
    assign tx_halt = enhanced_feature_i[`UAFC_EFR_ACTS] && cts_s;
    assign txq_pop = (st.tx_st == uafc_pkg::UAFC_TX_IDLE) && !thr_empty
                   && !tx_halt;
    assign auto_rts = enhanced_feature_i[`UAFC_EFR_ARTS]
                    && modem_control_i[`UAFC_MCR_RTS];
    assign rx_int = interrupt_enable[`UAFC_IER_RX] && (qen
                  ? (st.rx_cnt >= (AW+1)'(trig_lvl(tsel, 2'h0)))
                  : (st.rx_cnt != '0));
    // Four word lengths plus twelve bit times, in oversample ticks
    assign to_limit = (`UAFC_TOUT_CHARS * {8'h0, char_bits(line_control_i)}
                    + `UAFC_TOUT_BITS) * {7'h0, div};

    uafc_buf2 #(
        .W(11)
    ) u_rx_buf (
        .core_clk_i(core_clk_i),
        .reset_i(reset_i),
        .in_valid_i(st.rx_push),
        .in_ready_o(buf_in_ready),
        .in_data_i(st.rx_ent),
        .out_valid_o(buf_valid),
        .out_ready_i(st.rx_cnt < limit),
        .out_data_o(buf_data)
    );

    always_comb begin
        next_st = st;
        next_st.rx_sync = {st.rx_sync[0], rx_i};
        next_st.rx_prev = rx_s;
        next_st.cts_sync = {st.cts_sync[0], cts_n_i};
        next_st.cts_prev = cts_s;
        next_st.rx_push = 1'b0;

        // Receiver
        case (st.rx_st)
            uafc_pkg::UAFC_RX_IDLE: begin
                if (!rx_s && st.rx_prev) begin
                    next_st.rx_st = uafc_pkg::UAFC_RX_START;
                    next_st.rx_tick = '0;
                end
            end
            uafc_pkg::UAFC_RX_START: begin
                if (os_tick_i) begin
                    next_st.rx_tick = st.rx_tick + 5'h01;
                    if (st.rx_tick + 5'h01 == (div >> 1)) begin
                        next_st.rx_tick = '0;
                        next_st.rx_bit = '0;
                        next_st.rx_ent = '0;
                        next_st.rx_st = rx_s ? uafc_pkg::UAFC_RX_IDLE
                                             : uafc_pkg::UAFC_RX_DATA;
                    end
                end
            end
            uafc_pkg::UAFC_RX_DATA: begin
                if (os_tick_i) begin
                    next_st.rx_tick = st.rx_tick + 5'h01;
                    if (st.rx_tick + 5'h01 == div) begin
                        next_st.rx_tick = '0;
                        next_st.rx_ent.data[st.rx_bit] = rx_s;
                        next_st.rx_bit = st.rx_bit + 3'h1;
                        if (st.rx_bit == {1'b1, line_control_i[
                                `UAFC_LCR_WL_HI:`UAFC_LCR_WL_LO]}) begin
                            next_st.rx_st = line_control_i[`UAFC_LCR_PEN]
                                ? uafc_pkg::UAFC_RX_PAR
                                : uafc_pkg::UAFC_RX_STOP;
                        end
                    end
                end
            end
            uafc_pkg::UAFC_RX_PAR: begin
                if (os_tick_i) begin
                    next_st.rx_tick = st.rx_tick + 5'h01;
                    if (st.rx_tick + 5'h01 == div) begin
                        next_st.rx_tick = '0;
                        next_st.rx_ent.par = rx_s
                            ^ par_bit(st.rx_ent.data, line_control_i);
                        next_st.rx_st = uafc_pkg::UAFC_RX_STOP;
                    end
                end
            end
            uafc_pkg::UAFC_RX_STOP: begin
                if (os_tick_i) begin
                    next_st.rx_tick = st.rx_tick + 5'h01;
                    if (st.rx_tick + 5'h01 == div) begin
                        next_st.rx_ent.frm = !rx_s;
                        next_st.rx_ent.brk = !rx_s
                            && (st.rx_ent.data == 8'h00);
                        next_st.rx_push = 1'b1;
                        next_st.rx_st = uafc_pkg::UAFC_RX_IDLE;
                    end
                end
            end
            default: begin
                next_st.rx_st = uafc_pkg::UAFC_RX_IDLE;
            end
        endcase

        // Buffer full means both queue and buffer are full
        if (st.rx_push && !buf_in_ready) begin
            next_st.ovr = 1'b1;
        end else if (rxq_pop) begin
            next_st.ovr = 1'b0;
        end

        // Receive queue, 11 bits per entry
        if (rxq_push) begin
            next_st.rxq[st.rx_wp] = buf_data;
            next_st.rx_wp = st.rx_wp + AW'(1);
        end
        if (rxq_pop) begin
            next_st.rx_rp = st.rx_rp + AW'(1);
        end
        next_st.rx_cnt = st.rx_cnt + (AW+1)'(rxq_push)
                       - (AW+1)'(rxq_pop);

        // Receive timeout, restarted by any queue activity
        if (st.rx_cnt == '0 || rxq_push || rxq_pop) begin
            next_st.to_cnt = '0;
            next_st.to_pend = 1'b0;
        end else if (os_tick_i) begin
            if (st.to_cnt + 12'h001 >= to_limit) begin
                next_st.to_pend = 1'b1;
            end else begin
                next_st.to_cnt = st.to_cnt + 12'h001;
            end
        end

        // Transmit queue
        if (txq_push) begin
            next_st.txq[st.tx_wp] = tx_data_i;
            next_st.tx_wp = st.tx_wp + AW'(1);
        end
        if (txq_pop) begin
            next_st.tx_rp = st.tx_rp + AW'(1);
        end
        next_st.tx_cnt = st.tx_cnt + (AW+1)'(txq_push)
                       - (AW+1)'(txq_pop);

        // Transmitter; CTS only checked between characters
        case (st.tx_st)
            uafc_pkg::UAFC_TX_IDLE: begin
                next_st.tx_line = 1'b1;
                if (txq_pop) begin
                    next_st.tx_sh = st.txq[st.tx_rp]
                                  & wl_mask(line_control_i);
                    next_st.tx_par = par_bit(st.txq[st.tx_rp]
                        & wl_mask(line_control_i), line_control_i);
                    next_st.tx_tick = '0;
                    next_st.tx_line = 1'b0;
                    next_st.tx_st = uafc_pkg::UAFC_TX_START;
                end
            end
            uafc_pkg::UAFC_TX_START, uafc_pkg::UAFC_TX_DATA,
            uafc_pkg::UAFC_TX_PAR, uafc_pkg::UAFC_TX_STOP: begin
                if (os_tick_i) begin
                    next_st.tx_tick = st.tx_tick + 5'h01;
                    if (st.tx_tick + 5'h01 == div) begin
                        next_st.tx_tick = '0;
                        case (st.tx_st)
                            uafc_pkg::UAFC_TX_START: begin
                                next_st.tx_bit = '0;
                                next_st.tx_line = st.tx_sh[0];
                                next_st.tx_sh = st.tx_sh >> 1;
                                next_st.tx_st = uafc_pkg::UAFC_TX_DATA;
                            end
                            uafc_pkg::UAFC_TX_DATA: begin
                                next_st.tx_bit = st.tx_bit + 3'h1;
                                next_st.tx_line = st.tx_sh[0];
                                next_st.tx_sh = st.tx_sh >> 1;
                                if (st.tx_bit == {1'b1, line_control_i[
                                    `UAFC_LCR_WL_HI:`UAFC_LCR_WL_LO]}) begin
                                    next_st.tx_stop2 =
                                        line_control_i[`UAFC_LCR_STOP];
                                    if (line_control_i[`UAFC_LCR_PEN]) begin
                                        next_st.tx_line = st.tx_par;
                                        next_st.tx_st =
                                            uafc_pkg::UAFC_TX_PAR;
                                    end else begin
                                        next_st.tx_line = 1'b1;
                                        next_st.tx_st =
                                            uafc_pkg::UAFC_TX_STOP;
                                    end
                                end
                            end
                            uafc_pkg::UAFC_TX_PAR: begin
                                next_st.tx_line = 1'b1;
                                next_st.tx_st = uafc_pkg::UAFC_TX_STOP;
                            end
                            default: begin
                                next_st.tx_stop2 = 1'b0;
                                if (!st.tx_stop2) begin
                                    next_st.tx_st = uafc_pkg::UAFC_TX_IDLE;
                                end
                            end
                        endcase
                    end
                end
            end
            default: begin
                next_st.tx_st = uafc_pkg::UAFC_TX_IDLE;
            end
        endcase

        // Auto RTS hysteresis; queue keeps filling while off
        if (!auto_rts) begin
            next_st.rts_off = 1'b0;
        end else if (st.rx_cnt >= (AW+1)'(trig_lvl(tsel, 2'h1))) begin
            next_st.rts_off = 1'b1;
        end else if (st.rx_cnt <= (AW+1)'(trig_lvl(tsel, 2'h2))) begin
            next_st.rts_off = 1'b0;
        end
        next_st.rts_n = !modem_control_i[`UAFC_MCR_RTS]
                      || (auto_rts && next_st.rts_off);

        // Sticky interrupt flags; a new event beats the clear
        next_st.thr_prev = thr_empty;
        if (isr_read_i || tx_write_i) begin
            next_st.tx_pend = 1'b0;
        end
        if (thr_empty && !st.thr_prev && interrupt_enable[`UAFC_IER_TX]) begin
            next_st.tx_pend = 1'b1;
        end
        if (isr_read_i) begin
            next_st.flow_pend = 1'b0;
        end
        if (next_st.rts_n && !st.rts_n
            && interrupt_enable[`UAFC_IER_RTS]) begin
            next_st.flow_pend = 1'b1;
        end
        if (enhanced_feature_i[`UAFC_EFR_ACTS] && cts_s && !st.cts_prev
            && interrupt_enable[`UAFC_IER_CTS]) begin
            next_st.flow_pend = 1'b1;
        end
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= init_st();
        end else begin
            st <= next_st;
        end
    end

    always_comb begin
        line_status_o = 8'h00;
        line_status_o[`UAFC_LSR_DR] = (st.rx_cnt != '0);
        line_status_o[`UAFC_LSR_OE] = st.ovr;
        line_status_o[`UAFC_LSR_PE] = (st.rx_cnt != '0) && head.par;
        line_status_o[`UAFC_LSR_FE] = (st.rx_cnt != '0) && head.frm;
        line_status_o[`UAFC_LSR_BI] = (st.rx_cnt != '0) && head.brk;
        line_status_o[`UAFC_LSR_THRE] = thr_empty;
        line_status_o[`UAFC_LSR_TEMT] = thr_empty
            && (st.tx_st == uafc_pkg::UAFC_TX_IDLE);
    end

    // Highest priority source reported first
    always_comb begin
        if (st.to_pend && interrupt_enable[`UAFC_IER_RX]) begin
            interrupt_source_o = `UAFC_ISR_TOUT;
        end else if (rx_int) begin
            interrupt_source_o = `UAFC_ISR_RX;
        end else if (st.tx_pend) begin
            interrupt_source_o = `UAFC_ISR_TX;
        end else if (st.flow_pend) begin
            interrupt_source_o = `UAFC_ISR_FLOW;
        end else begin
            interrupt_source_o = `UAFC_ISR_NONE;
        end
    end

    assign irq_o = (interrupt_source_o != `UAFC_ISR_NONE);
    assign rx_data_o = head.data;
    assign tx_o = st.tx_line;
    assign rts_n_o = st.rts_n;
endmodule // uafc_path

// [uafc_defs.svh]
// Purpose: Named offsets, field positions and counts for the serial data path
// Assumes: Included by bare name from the design modules
// Notes: Definitions only
`ifndef UAFC_DEFS_SVH
`define UAFC_DEFS_SVH

`define UAFC_DEPTH 64
`define UAFC_CNT_ONE 7'h01
`define UAFC_CNT_ZERO 7'h00

`define UAFC_FCR_EN 0
`define UAFC_FCR_TRIG_HI 7
`define UAFC_FCR_TRIG_LO 6

`define UAFC_IER_RX 0
`define UAFC_IER_TX 1
`define UAFC_IER_RTS 6
`define UAFC_IER_CTS 7

`define UAFC_EFR_ENH 4
`define UAFC_EFR_ARTS 6
`define UAFC_EFR_ACTS 7

`define UAFC_MCR_RTS 1

`define UAFC_LCR_WL_HI 1
`define UAFC_LCR_WL_LO 0
`define UAFC_LCR_STOP 2
`define UAFC_LCR_PEN 3
`define UAFC_LCR_EPS 4
`define UAFC_WL_MIN 4'h5

`define UAFC_DLD_OS_HI 5
`define UAFC_DLD_OS_LO 4
`define UAFC_OS_16X 2'h0
`define UAFC_OS_8X 2'h1
`define UAFC_OS16 5'h10
`define UAFC_OS8 5'h08
`define UAFC_OS4 5'h04

`define UAFC_TOUT_CHARS 12'h004
`define UAFC_TOUT_BITS 12'h00c

`define UAFC_TRIG_8 7'h08
`define UAFC_TRIG_16 7'h10
`define UAFC_TRIG_56 7'h38
`define UAFC_TRIG_60 7'h3c

`define UAFC_LSR_DR 0
`define UAFC_LSR_OE 1
`define UAFC_LSR_PE 2
`define UAFC_LSR_FE 3
`define UAFC_LSR_BI 4
`define UAFC_LSR_THRE 5
`define UAFC_LSR_TEMT 6

`define UAFC_ISR_NONE 8'h01
`define UAFC_ISR_TX 8'h02
`define UAFC_ISR_RX 8'h04
`define UAFC_ISR_TOUT 8'h0c
`define UAFC_ISR_FLOW 8'h20

`endif

// [uafc_pkg.sv]
// Purpose: Shared types of the serial data path
// Assumes: Constants live in uafc_defs.svh
// Notes: State codes are one-hot
package uafc_pkg;

    typedef enum logic [4:0] {
        UAFC_RX_IDLE = 5'h01,
        UAFC_RX_START = 5'h02,
        UAFC_RX_DATA = 5'h04,
        UAFC_RX_PAR = 5'h08,
        UAFC_RX_STOP = 5'h10
    } uafc_rx_st_t;

    typedef enum logic [4:0] {
        UAFC_TX_IDLE = 5'h01,
        UAFC_TX_START = 5'h02,
        UAFC_TX_DATA = 5'h04,
        UAFC_TX_PAR = 5'h08,
        UAFC_TX_STOP = 5'h10
    } uafc_tx_st_t;

    // One receive queue entry: byte plus three error tags
    typedef struct packed {
        logic brk;
        logic frm;
        logic par;
        logic [7:0] data;
    } uafc_rx_entry_t;

endpackage

// [uafc_buf2.sv]
// Purpose: Two-entry valid/ready buffer
// Assumes: Single clock, asynchronous active-high reset
// Notes: Full throughput; out_ready low stalls and fills it
`timescale 1ns/10ps
module uafc_buf2 #(
    parameter int W = 11
) (
    input wire logic core_clk_i,
    input wire logic reset_i,
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [W-1:0] in_data_i,
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [W-1:0] out_data_o
);
    typedef struct packed {
        logic [1:0][W-1:0] slot;
        logic [1:0] cnt;
    } uafc_buf_st_t;

    uafc_buf_st_t st;
    uafc_buf_st_t next_st;
    logic push;
    logic pop;

    assign in_ready_o = (st.cnt != 2'h2);
    assign out_valid_o = (st.cnt != 2'h0);
    assign out_data_o = st.slot[0];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        next_st = st;
        if (pop) begin
            next_st.slot[0] = st.slot[1];
        end
        if (push) begin
            if (st.cnt == 2'h0 || (st.cnt == 2'h1 && pop)) begin
                next_st.slot[0] = in_data_i;
            end else begin
                next_st.slot[1] = in_data_i;
            end
        end
        next_st.cnt = st.cnt + {1'b0, push} - {1'b0, pop};
    end

    always_ff @(posedge core_clk_i or posedge reset_i) begin
        if (reset_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule // uafc_buf2

// [uafc_path_props.sv]
// Purpose: Concurrent checks on the serial data path ports
// Assumes: Single clock domain, async active-high reset
// Notes: Bound into every uafc_path instance
`timescale 1ns/10ps
module uafc_path_props (
    input wire logic core_clk_i, reset_i, os_tick_i, tx_write_i,
    input wire logic [7:0] queue_control_i, enhanced_feature_i,
    input wire logic [7:0] modem_control_i, interrupt_enable_i,
    input wire logic [7:0] fractional_divisor_i,
    input wire logic tx_o, rts_n_o, irq_o,
    input wire logic [7:0] line_status_o, interrupt_source_o
);
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (reset_i);
    property p_irq; irq_o == (interrupt_source_o != 8'h01); endproperty
    a_irq: assert property (p_irq) else $error("irq vs source");
    property p_idle; line_status_o[6] |-> tx_o; endproperty
    a_idle: assert property (p_idle) else $error("line not idle");
    property p_temt; tx_write_i && line_status_o[6] |=> !line_status_o[6];
    endproperty
    a_temt: assert property (p_temt) else $error("empty stays");
    property p_thre; tx_write_i && queue_control_i[0] && line_status_o[5]
        |=> !line_status_o[5]; endproperty
    a_thre: assert property (p_thre) else $error("hold empty");
    property p_start; $fell(tx_o) && os_tick_i
        && fractional_divisor_i[5:4] == 2'h2 |-> (!tx_o) [*4]; endproperty
    a_start: assert property (p_start) else $error("bit len");
    property p_rtsup; $rose(rts_n_o) && enhanced_feature_i[6]
        |-> line_status_o[0] || !modem_control_i[1]; endproperty
    a_rtsup: assert property (p_rtsup) else $error("rts off");
    property p_rtsint; $rose(rts_n_o) && interrupt_enable_i[6]
        && enhanced_feature_i[4] |-> irq_o; endproperty
    a_rtsint: assert property (p_rtsint) else $error("rts irq");
    property p_rtson; $fell(rts_n_o) |-> $past(modem_control_i[1]);
    endproperty
    a_rtson: assert property (p_rtson) else $error("rts on");
endmodule // uafc_path_props
bind uafc_path uafc_path_props u_props(.core_clk_i(core_clk_i),
    .reset_i(reset_i), .os_tick_i(os_tick_i), .tx_write_i(tx_write_i),
    .queue_control_i(queue_control_i), .tx_o(tx_o), .irq_o(irq_o),
    .enhanced_feature_i(enhanced_feature_i), .rts_n_o(rts_n_o),
    .modem_control_i(modem_control_i), .line_status_o(line_status_o),
    .interrupt_enable_i(interrupt_enable_i),
    .fractional_divisor_i(fractional_divisor_i),
    .interrupt_source_o(interrupt_source_o));

// [uafc_remote.sv]
// Purpose: Remote sender feeding the receive line
// Assumes: 4X with a tick each cycle, 8N1
// Notes: Looks at request-to-send only between characters
`timescale 1ns/10ps
module uafc_remote (
    input wire logic core_clk_i,
    input wire logic rts_n_i,
    output logic line_o
);
    initial line_o = 1'b1;
    // Shorter than half a bit, so never a valid start
    task automatic glitch();
        @(posedge core_clk_i) line_o <= 1'b0;
        @(posedge core_clk_i) line_o <= 1'b1;
    endtask
    task automatic send(input logic [7:0] b, input int gap);
        logic [9:0] f;
        int i;
        f = {1'b1, b, 1'b0};
        repeat (gap) @(posedge core_clk_i);
        for (i = 0; rts_n_i !== 1'b0 && i < 9000; i++) begin
            @(posedge core_clk_i);
        end
        for (int k = 0; k < 10; k++) begin
            @(posedge core_clk_i) line_o <= f[k];
            repeat (3) @(posedge core_clk_i);
        end
    endtask
endmodule // uafc_remote

// [uafc_path_tb_top.sv]
// Purpose: Self-checking bench for the serial data path
// Assumes: 4X oversampling, tick every cycle, 8N1, trigger 8
// Notes: Auto RTS and CTS both exercised
`timescale 1ns/10ps
module uafc_path_tb_top;
    logic clk = 0, rst = 1, wr = 0, rd = 0, cts = 0, txo, rts, irq, ln;
    logic ird = 0;
    logic [7:0] wd = 8'h00, interrupt_enable = 8'hc3, modem_control = 8'h00, enhanced_feature = 8'hd0;
    logic [7:0] rdo, line_status, interrupt_source, s[20], q[$];
    int n_errors = 0, checked = 0, i;
    initial forever #12.5 clk = ~clk;
    uafc_path u_uafc_path(.core_clk_i(clk), .reset_i(rst), .os_tick_i(1'b1),
        .tx_write_i(wr), .tx_data_i(wd), .rx_read_i(rd), .rx_data_o(rdo),
        .isr_read_i(ird), .interrupt_enable_i(interrupt_enable), .queue_control_i(8'h01),
        .enhanced_feature_i(enhanced_feature), .modem_control_i(modem_control), .tx_o(txo),
        .fractional_divisor_i(8'h20), .line_control_i(8'h03), .rx_i(ln),
        .cts_n_i(cts), .rts_n_o(rts), .line_status_o(line_status),
        .interrupt_source_o(interrupt_source), .irq_o(irq));
    uafc_remote u_uafc_remote(.core_clk_i(clk), .rts_n_i(rts), .line_o(ln));
    task automatic chk(input logic ok, input string m);
        checked++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED %0t %s", $time, m);
        end
    endtask
    // Host read of the interrupt source, one edge wide
    task automatic clr_isr();
        @(posedge clk) ird <= 1'b1;
        @(posedge clk) ird <= 1'b0;
    endtask
    task automatic close_out();
        $display("errors %0d checks %0d", n_errors, checked);
        if (n_errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // A bounded wait that ran dry ends the run
    task automatic give_up();
        if (i >= 3000) begin
            n_errors++;
            close_out();
        end
    endtask
    function automatic logic [9:0] frame(input logic [7:0] b);
        return {1'b1, b, 1'b0};
    endfunction
    task automatic grab(input logic [7:0] b);
        logic [9:0] f;
        f = frame(b);
        for (i = 0; txo !== 1'b0 && i < 3000; i++) @(negedge clk);
        give_up();
        @(negedge clk);
        for (int k = 0; k < 10; k++) begin
            chk(txo === f[k], "tx bit");
            repeat (4) @(negedge clk);
        end
    endtask
    initial begin
        void'($urandom(3));
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        repeat (4) @(posedge clk);
        chk(rts === 1'b1 && line_status === 8'h60, "idle");
        chk(interrupt_source === 8'h01, "no false irq");
        modem_control <= 8'h02;
        cts <= 1'b1;
        repeat (4) @(posedge clk);
        for (i = 0; i < 3; i++) begin
            s[i] = (i == 0) ? 8'h80 : 8'($urandom);
            @(posedge clk);
            wr <= 1'b1;
            wd <= s[i];
        end
        @(posedge clk) wr <= 1'b0;
        repeat (60) @(posedge clk);
        chk(txo === 1'b1 && line_status[6:5] === 2'b00, "halt");
        chk(interrupt_source === 8'h20, "cts irq");
        clr_isr();
        cts <= 1'b0;
        for (int k = 0; k < 3; k++) grab(s[k]);
        repeat (8) @(posedge clk);
        chk(line_status[6:5] === 2'b11, "tx empty");
        chk(interrupt_source === 8'h02, "tx irq");
        clr_isr();
        u_uafc_remote.glitch();
        repeat (20) @(posedge clk);
        chk(line_status[0] === 1'b0, "false start");
        chk(interrupt_source === 8'h01, "irq cleared");
        for (i = 0; i < 20; i++) begin
            s[i] = 8'($urandom);
            q.push_back(s[i]);
        end
        fork
            for (int k = 0; k < 20; k++) u_uafc_remote.send(s[k], $urandom % 4);
        join_none
        for (i = 0; rts !== 1'b1 && i < 3000; i++) @(negedge clk);
        give_up();
        chk(irq === 1'b1 && line_status[0] === 1'b1, "flow off");
        // Remote is held off, so the queue sits idle
        repeat (300) @(negedge clk);
        chk(interrupt_source === 8'h0c, "timeout");
        for (i = 0; q.size() > 0 && i < 3000; i++) begin
            @(negedge clk);
            if (line_status[0] === 1'b1) begin
                chk(rdo === q.pop_front() && line_status[4:2] === 3'h0, "rx");
                @(posedge clk) rd <= 1'b1;
                @(posedge clk) rd <= 1'b0;
            end
        end
        give_up();
        @(negedge clk);
        chk(rts === 1'b0, "flow on");
        chk(interrupt_source === 8'h20, "rts irq");
        clr_isr();
        @(negedge clk);
        chk(interrupt_source === 8'h01 && irq === 1'b0, "flow clear");
        close_out();
    end
endmodule // uafc_path_tb_top
